// ---- wwd_top.sv ----
`timescale 1ns/100ps
module wwd_top
  import wwd_pkg::*;
#(
  parameter logic [4:0] BASE_EXP = OVF_BASE_EXP
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic variable_code_startup_option,
  input wire logic [2:0] overflow_startup_option,
  input wire logic warning_irq_startup_option,
  input wire logic [1:0] window_startup_option,
  output logic three_quarter_warning_irq,
  output logic nmi_req,
  output logic reset_req,
  output logic irq
);
  // ****************************************
  // reset release
  // ****************************************
  logic rs1_r;
  logic rst_n;

  // two-stage release of the async reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end

  // ****************************************
  // state
  // ****************************************
  logic opt_done_r;
  logic var_code_en_r;
  logic run_r;
  logic [6:0] mode_r;
  logic [6:0] act_r;
  logic [7:0] ref_r;
  logic [7:0] last_code_r;
  logic [IRQ_W-1:0] stat_r;
  logic [IRQ_W-1:0] mask_r;
  logic ack_r;
  logic ovf_pulse;
  logic warn_pulse;
  logic win_open;

  // ****************************************
  // bus decode
  // ****************************************
  wire logic req_w = wb_cyc_i & wb_stb_i;
  wire logic start_w = req_w & ~ack_r;
  wire logic done_w = req_w & ack_r;
  wire logic wr_w = done_w & wb_we_i & wb_sel_i[0];
  wire logic rd_w = done_w & ~wb_we_i;
  wire logic [7:0] wdat_w = wb_dat_i[7:0];
  wire logic hit_fix_w = (wb_adr_i == ADR_FIX_TRIG);
  wire logic hit_var_w = (wb_adr_i == ADR_VAR_TRIG);
  wire logic hit_ref_w = (wb_adr_i == ADR_REF);
  wire logic hit_mode_w = (wb_adr_i == ADR_MODE);
  wire logic hit_stat_w = (wb_adr_i == ADR_IRQ_STAT);
  wire logic hit_mask_w = (wb_adr_i == ADR_IRQ_MASK);
  wire logic fix_wr_w = wr_w & hit_fix_w;
  wire logic var_wr_w = wr_w & hit_var_w;
  wire logic mode_wr_w = wr_w & hit_mode_w;
  wire logic stat_rd_w = rd_w & hit_stat_w;

  assign wb_ack_o = ack_r;

  // ****************************************
  // active mode fields
  // ****************************************
  wire logic [2:0] ovf_sel_w = act_r[OVF_LSB +: 3];
  wire logic wie_w = act_r[WIE_BIT];
  wire logic erm_w = act_r[ERM_BIT];
  wire logic [1:0] ws_w = act_r[WS_LSB +: 2];

  // ****************************************
  // trigger and error detection
  // ****************************************
  wire logic [7:0] exp_code_w = TRIG_CODE - ref_r;
  wire logic fix_ok_w = fix_wr_w & (wdat_w == TRIG_CODE);
  wire logic var_ok_w = var_wr_w & (wdat_w == exp_code_w);
  wire logic code_ok_w = var_code_en_r ? var_ok_w : fix_ok_w;
  wire logic fix_bad_w = fix_wr_w & (wdat_w != TRIG_CODE);
  wire logic var_bad_w = var_wr_w & (wdat_w != exp_code_w);
  wire logic code_bad_w = var_code_en_r ? var_bad_w : fix_bad_w;
  wire logic win_bad_w = code_ok_w & run_r & ~win_open;
  wire logic trig_go_w = code_ok_w & ~win_bad_w;
  wire logic mode_bad_w = mode_wr_w & run_r & (wdat_w[6:0] != mode_r);
  wire logic err_w = code_bad_w | win_bad_w | mode_bad_w;
  wire logic fault_w = err_w | ovf_pulse;
  wire logic [7:0] ref_nxt_w = {ref_r[6:0], ~(ref_r[7] ^ ref_r[5] ^ ref_r[4] ^ ref_r[3])};
  wire logic [IRQ_W-1:0] ev_w = {ovf_pulse, err_w, warn_pulse & wie_w};

  // ****************************************
  // read data
  // ****************************************
  wire logic [7:0] rd_fix_w = var_code_en_r ? IDLE_CODE : {run_r, IDLE_CODE[6:0]};
  wire logic [7:0] rd_var_w = var_code_en_r ? last_code_r : IDLE_CODE;
  wire logic [7:0] rd_ref_w = var_code_en_r ? ref_r : 8'h00;
  wire logic [7:0] rd_mode_w = {1'b0, mode_r};
  wire logic [7:0] rd_stat_w = {{(8-IRQ_W){1'b0}}, stat_r};
  wire logic [7:0] rd_mask_w = {{(8-IRQ_W){1'b0}}, mask_r};
  wire logic [7:0] rdata_w =
    hit_fix_w ? rd_fix_w :
    hit_var_w ? rd_var_w :
    hit_ref_w ? rd_ref_w :
    hit_mode_w ? rd_mode_w :
    hit_stat_w ? rd_stat_w :
    hit_mask_w ? rd_mask_w : 8'h00;

  // ****************************************
  // wishbone answer, one wait state
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack_r <= start_w;
      if (start_w) begin
        wb_dat_o <= {24'h000000, rdata_w};
      end
    end
  end

  // ****************************************
  // start-up options, mode and run state
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opt_done_r <= 1'b0;
      var_code_en_r <= 1'b0;
      mode_r <= MODE_RST;
      act_r <= MODE_RST;
      run_r <= 1'b0;
    end else if (!opt_done_r) begin
      // options caught in the first cycle after release
      opt_done_r <= 1'b1;
      var_code_en_r <= variable_code_startup_option;
      mode_r <= {overflow_startup_option, warning_irq_startup_option, 1'b1,
                 window_startup_option};
      act_r <= {overflow_startup_option, warning_irq_startup_option, 1'b1,
                window_startup_option};
    end else begin
      if (mode_wr_w && !run_r) begin
        mode_r <= wdat_w[6:0];
      end
      if (trig_go_w) begin
        act_r <= mode_r;
        run_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // reference value and last code
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_r <= REF_RST;
      last_code_r <= IDLE_CODE;
    end else begin
      if (trig_go_w) begin
        ref_r <= ref_nxt_w;
      end
      if (var_wr_w && var_code_en_r) begin
        last_code_r <= wdat_w;
      end
    end
  end

  // ****************************************
  // error response and warning outputs
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nmi_req <= 1'b0;
      reset_req <= 1'b0;
      three_quarter_warning_irq <= 1'b0;
    end else begin
      nmi_req <= fault_w & ~erm_w;
      reset_req <= fault_w & erm_w;
      three_quarter_warning_irq <= warn_pulse & wie_w;
    end
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= '0;
      mask_r <= MASK_RST;
    end else begin
      // a new event wins over the read clear
      stat_r <= (stat_rd_w ? '0 : stat_r) | ev_w;
      if (wr_w && hit_mask_w) begin
        mask_r <= wdat_w[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(stat_r & mask_r);

  // ****************************************
  // counter and window
  // ****************************************
  wwd_counter #(
    .CW(CNT_W),
    .BASE_EXP(BASE_EXP)
  ) u_counter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(run_r),
    .restart(trig_go_w),
    .ovf_sel(ovf_sel_w),
    .win_sel(ws_w),
    .ovf_pulse(ovf_pulse),
    .warn_pulse(warn_pulse),
    .win_open(win_open)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_mode_change_run;
    mode_wr_w && run_r && (wdat_w[6:0] != mode_r);
  endsequence

  sequence s_fault_out;
    ##1 (nmi_req || reset_req);
  endsequence

  ref_zero_a: assert property (
    (start_w && hit_ref_w && !var_code_en_r) |=> wb_ack_o && wb_dat_o == 32'h0)
    else $error("reference read not zero with variable code off");

  mode_bit7_a: assert property (
    (start_w && hit_mode_w) |=> wb_dat_o[7] == 1'b0)
    else $error("mode bit 7 read as one");

  mode_hold_a: assert property (
    (opt_done_r && !trig_go_w) |=> act_r == $past(act_r))
    else $error("active mode changed without trigger");

  mode_apply_a: assert property (
    trig_go_w |=> act_r == $past(mode_r))
    else $error("written mode not applied at trigger");

  mode_err_a: assert property (s_mode_change_run |-> s_fault_out)
    else $error("mode change after start not flagged");

  run_stick_a: assert property (run_r |=> run_r)
    else $error("running state cleared");

  err_route_a: assert property (
    (fault_w && erm_w) |=> reset_req && !nmi_req)
    else $error("reset response not routed");

  warn_gate_a: assert property (
    three_quarter_warning_irq |-> $past(wie_w) && $past(warn_pulse))
    else $error("warning without enable");

  bad_code_a: assert property (fix_bad_w && !var_code_en_r |-> s_fault_out)
    else $error("wrong fixed code not flagged");

  ref_upd_a: assert property (trig_go_w |=> ref_r == $past(ref_nxt_w))
    else $error("reference not refreshed on trigger");
endmodule

// ---- wwd_pkg.sv ----
// Overview of operation
// - reference value refreshed after every trigger not flagged as an error
// - reference reads zero without variable code
// - reference is read-only, resets to zero
// - new mode applies from next trigger
// - changing mode after start raises error
// - mode bit 7 ignores writes, reads 0
// - overflow field divides input clock by 2^(9+n)
// - bit 3 gates the 75% warning
// - bit 2 picks error response
// - bits 1:0 pick open window size
// - mode fields reset from start-up options, except bit 2, which resets to 1
// - wrong trigger code is an error
// - running watchdog stops only on reset
package wwd_pkg;
  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] ADR_FIX_TRIG = 8'h00;
  localparam logic [7:0] ADR_VAR_TRIG = 8'h04;
  localparam logic [7:0] ADR_REF = 8'h08;
  localparam logic [7:0] ADR_MODE = 8'h0C;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h14;

  // ****************************************
  // codes, reset values, field positions
  // ****************************************
  localparam logic [7:0] TRIG_CODE = 8'hAC;
  localparam logic [7:0] IDLE_CODE = 8'h2C;
  localparam logic [7:0] REF_RST = 8'h00;
  localparam logic [6:0] MODE_RST = 7'h04;
  localparam int OVF_LSB = 4;
  localparam int WIE_BIT = 3;
  localparam int ERM_BIT = 2;
  localparam int WS_LSB = 0;
  localparam logic [4:0] OVF_BASE_EXP = 5'h09;
  localparam int CNT_W = 17;

  // ****************************************
  // interrupt status bits
  // ****************************************
  localparam int IRQ_W = 3;
  localparam int IRQ_WARN = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_OVF = 2;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
endpackage

// ---- wwd_counter.sv ----
`timescale 1ns/100ps
module wwd_counter
  import wwd_pkg::*;
#(
  parameter int CW = CNT_W,
  parameter logic [4:0] BASE_EXP = OVF_BASE_EXP
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic restart,
  input wire logic [2:0] ovf_sel,
  input wire logic [1:0] win_sel,
  output logic ovf_pulse,
  output logic warn_pulse,
  output logic win_open
);
  // ****************************************
  // interval arithmetic
  // ****************************************
  logic [CW-1:0] cnt_r;
  wire logic [4:0] exp_w = BASE_EXP + {2'h0, ovf_sel};
  wire logic [CW-1:0] top_w = {{(CW-1){1'b0}}, 1'b1} << exp_w;
  wire logic [CW-1:0] quarter_w = top_w >> 2;
  wire logic [CW-1:0] warn_at_w = top_w - quarter_w - {{(CW-1){1'b0}}, 1'b1};
  wire logic [CW-1:0] open_w = quarter_w * CW'({1'b0, win_sel} + 3'h1);
  wire logic last_w = (cnt_r == top_w - {{(CW-1){1'b0}}, 1'b1});
  wire logic live_w = run & ~restart;

  assign win_open = (cnt_r >= top_w - open_w);

  // ****************************************
  // count and event pulses
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      ovf_pulse <= 1'b0;
      warn_pulse <= 1'b0;
    end else begin
      ovf_pulse <= live_w & last_w;
      warn_pulse <= live_w & (cnt_r == warn_at_w);
      cnt_r <= (!live_w || last_w) ? '0 : cnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  warn_single_a: assert property (warn_pulse |=> !warn_pulse)
    else $error("warning pulse longer than one cycle");
  ovf_wrap_a: assert property (ovf_pulse |-> cnt_r == '0)
    else $error("counter not cleared at overflow");
endmodule

// ---- wwd_top_tb.sv ----
`timescale 1ns/100ps
module wwd_top_tb
  import wwd_pkg::*;
  ;
  logic clk_sys, rst_b, cyc, stb, we, ack, var_opt, wie_opt, warn, nmi, rreq, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dat_o, rdat;
  logic [2:0] ovf_opt;
  logic [1:0] ws_opt;
  int n_errors, num_checks, n_nmi, n_rst, n_warn, na, nb;

  wwd_top #(.BASE_EXP(5'h02)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .variable_code_startup_option(var_opt),
    .overflow_startup_option(ovf_opt), .warning_irq_startup_option(wie_opt),
    .window_startup_option(ws_opt), .three_quarter_warning_irq(warn), .nmi_req(nmi),
    .reset_req(rreq), .irq(irq));

  // ****************************************
  // clock and event pulse counters
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (nmi === 1'b1) n_nmi <= n_nmi + 1;
    if (rreq === 1'b1) n_rst <= n_rst + 1;
    if (warn === 1'b1) n_warn <= n_warn + 1;
  end

  // ****************************************
  // compare, verdict, bus and wait tasks
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; waits for ack, no fixed latency assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (ack !== 1'b1 && i < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rdat, {24'h000000, e});
  endtask

  // settle a few cycles, then compare fault pulse totals
  task automatic faults(input int en, input int er);
    repeat (5) @(posedge clk_sys);
    chk(n_nmi, en);
    chk(n_rst, er);
  endtask

  // cycles until the chosen event output is seen high
  task automatic wait_sig(input int which, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!((which == 0) ? warn === 1'b1 : (which == 1) ? nmi === 1'b1 : rreq === 1'b1)
               && n < 1000);
    if (n >= 1000) begin
      n_errors++;
      print_verdict();
    end
  endtask

  task automatic do_reset(input logic v, input logic [2:0] o, input logic i, input logic [1:0] w);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    var_opt <= v;
    ovf_opt <= o;
    wie_opt <= i;
    ws_opt <= w;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_b, cyc, stb, we, var_opt, wie_opt} = 6'h00;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h00000000;
    ovf_opt = 3'h0;
    ws_opt = 2'h0;
    {n_errors, num_checks, n_nmi, n_rst, n_warn} = '0;
    // fixed code mode, straps give mode 0x5E
    do_reset(1'b0, 3'h5, 1'b1, 2'h2);
    rd(ADR_MODE, 8'h5E);
    rd(ADR_REF, 8'h00);
    rd(ADR_IRQ_STAT, 8'h00);
    rd(ADR_IRQ_MASK, 8'h00);
    wr(ADR_MODE, 8'h11);
    wr(ADR_MODE, 8'hFB);
    rd(ADR_MODE, 8'h7B);
    // a write without byte lane 0 is dropped
    sel <= 4'hE;
    wr(ADR_MODE, 8'h11);
    sel <= 4'hF;
    rd(ADR_MODE, 8'h7B);
    wr(ADR_REF, 8'h55);
    rd(ADR_REF, 8'h00);
    wr(8'h20, 8'h33);
    rd(8'h20, 8'h00);
    rd(ADR_FIX_TRIG, IDLE_CODE);
    wr(ADR_IRQ_MASK, 8'h07);
    rd(ADR_IRQ_MASK, 8'h07);
    // start: top 512 cycles, warning near 384
    wr(ADR_FIX_TRIG, TRIG_CODE);
    wait_sig(0, na);
    wait_sig(1, nb);
    chk(na >= 382 && na <= 390, 1);
    chk(na + nb >= 510 && na + nb <= 518, 1);
    faults(1, 0);
    chk(n_warn, 1);
    chk(irq, 1'b1);
    rd(ADR_IRQ_STAT, 8'h05);
    // status clear lands at the ack edge, look one cycle later
    @(posedge clk_sys);
    chk(irq, 1'b0);
    rd(ADR_FIX_TRIG, 8'hAC);
    wr(ADR_FIX_TRIG, TRIG_CODE);
    faults(1, 0);
    rd(ADR_REF, 8'h00);
    wr(ADR_MODE, 8'h7A);
    faults(2, 0);
    rd(ADR_MODE, 8'h7B);
    wr(ADR_MODE, 8'h7B);
    faults(2, 0);
    wr(ADR_FIX_TRIG, 8'h12);
    faults(3, 0);
    rd(ADR_IRQ_STAT, 8'h02);
    // variable code mode, reset response, 25% window
    do_reset(1'b1, 3'h0, 1'b0, 2'h0);
    rd(ADR_MODE, 8'h04);
    wr(ADR_MODE, 8'h74);
    rd(ADR_MODE, 8'h74);
    rd(ADR_VAR_TRIG, IDLE_CODE);
    rd(ADR_FIX_TRIG, IDLE_CODE);
    wr(ADR_VAR_TRIG, 8'hAC);
    rd(ADR_REF, 8'h01);
    rd(ADR_VAR_TRIG, 8'hAC);
    wr(ADR_VAR_TRIG, 8'hAB);
    faults(3, 1);
    rd(ADR_REF, 8'h01);
    repeat (420) @(posedge clk_sys);
    wr(ADR_VAR_TRIG, 8'hAB);
    faults(3, 1);
    rd(ADR_REF, 8'h03);
    rd(ADR_IRQ_STAT, 8'h02);
    chk(n_warn, 1);
    // fixed trigger ignored here, a wrong variable code is an error
    wr(ADR_FIX_TRIG, 8'h12);
    faults(3, 1);
    wr(ADR_VAR_TRIG, 8'h00);
    faults(3, 2);
    rd(ADR_REF, 8'h03);
    rd(ADR_IRQ_STAT, 8'h02);
    print_verdict();
  end
endmodule
